// file: hw/alu_status_flags.sv
// Purpose: Arithmetic and system flag register with APB access
// Assumes: All inputs synchronous to clock; event inputs are pulses
// Notes:   Zero-wait APB slave; read data captured in the setup cycle
`timescale 1ns/1ps

// Function
// RULE_01 - Carry set on add carry or no borrow
// RULE_02 - Rotate through carry shifts bit into carry
// RULE_03 - Nibble carry from low nibble carry/no borrow
// RULE_04 - Zero flag set when result is zero
// RULE_05 - Wrap flag when carry in differs from out
// RULE_06 - Sign flag is wrap xor result msb
// RULE_07 - Subtract loads chained zero with zero
// RULE_08 - Borrow subtract ANDs chained zero with zero
// RULE_09 - Other instructions keep chained zero
// RULE_10 - Flag writes never touch timeout or sleep
// RULE_11 - Dog timeout cleared by reset/clear/halt, set
// RULE_12 - Sleep flag cleared by reset/clear, set halt
// RULE_13 - Six flags writable, two read-only zero reset
// RULE_14 - No automatic flag save on interrupt/call
// RULE_15 - Explicit flag write overrides same-cycle update
module alu_status_flags (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   reset,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // ALU operation
  input  wire logic                   op_valid,
  input  wire alu_flags_pkg::alu_op_t op_kind,
  input  wire logic [7:0]             op_a,
  input  wire logic [7:0]             op_b,
  output logic      [7:0]             alu_result,
  // Instruction write of the flag register
  input  wire logic                   instr_flag_write,
  input  wire logic [7:0]             instr_flag_data,
  // System events
  input  wire logic                   watchdog_clear_instr,
  input  wire logic                   halt_instr,
  input  wire logic                   watchdog_timeout,
  // Flag and interrupt outputs
  output logic      [7:0]             flags,
  output logic                        irq
);

  logic [7:0]               arith_flag_reg;
  logic [7:0]               next_arith_flag_reg;
  logic [7:0]               result_reg;
  logic [7:0]               next_result_reg;
  logic [2:0]               irq_status;
  logic [2:0]               next_irq_status;
  logic [2:0]               irq_enable;
  logic [2:0]               next_irq_enable;
  logic [31:0]              read_data;
  logic [31:0]              next_read_data;
  logic                     addr_bad;
  logic                     next_addr_bad;
  logic                     setup;
  logic                     access_wr;
  logic                     sw_flag_write;
  logic                     sw_irq_clear;
  logic                     sw_irq_enable;
  logic                     mapped;
  logic [2:0]               events;
  logic [7:0]               op_flags;

  flag_calc_if calc_bus ();

  alu_flag_calc u_calc (
    .calc (calc_bus)
  );

  assign calc_bus.op       = op_kind;
  assign calc_bus.op_a     = op_a;
  assign calc_bus.op_b     = op_b;
  assign calc_bus.carry_in = arith_flag_reg[alu_flags_pkg::FLAG_CARRY];

  // Bus decode
  assign setup     = psel && !penable;
  assign access_wr = psel && penable && pwrite;

  always_comb begin
    mapped = 1'b1;
    if (paddr == alu_flags_pkg::ADDR_FLAGS) begin
      mapped = 1'b1;
    end else if (paddr == alu_flags_pkg::ADDR_RESULT) begin
      mapped = 1'b1;
    end else if (paddr == alu_flags_pkg::ADDR_IRQ_STATUS) begin
      mapped = 1'b1;
    end else if (paddr == alu_flags_pkg::ADDR_IRQ_CLEAR) begin
      mapped = 1'b1;
    end else if (paddr == alu_flags_pkg::ADDR_IRQ_ENABLE) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // Writes land only at the access edge, lane 0 strobed
  assign sw_flag_write = access_wr && pstrb[0] && (paddr == alu_flags_pkg::ADDR_FLAGS);
  assign sw_irq_clear  = access_wr && pstrb[0] && (paddr == alu_flags_pkg::ADDR_IRQ_CLEAR);
  assign sw_irq_enable = access_wr && pstrb[0] && (paddr == alu_flags_pkg::ADDR_IRQ_ENABLE);

  // Read data captured in setup so the zero-wait answer comes from flops
  always_comb begin
    next_read_data = read_data;
    next_addr_bad  = addr_bad;
    if (setup) begin
      next_addr_bad  = !mapped;
      next_read_data = 32'h0000_0000;
      if (paddr == alu_flags_pkg::ADDR_FLAGS) begin
        next_read_data = {24'h00_0000, arith_flag_reg};
      end else if (paddr == alu_flags_pkg::ADDR_RESULT) begin
        next_read_data = {24'h00_0000, result_reg};
      end else if (paddr == alu_flags_pkg::ADDR_IRQ_STATUS) begin
        next_read_data = {29'h0, irq_status};
      end else if (paddr == alu_flags_pkg::ADDR_IRQ_ENABLE) begin
        next_read_data = {29'h0, irq_enable};
      end else begin
        next_read_data = 32'h0000_0000;
      end
    end
  end

  // Flag update from the ALU and system events
  always_comb begin
    op_flags = arith_flag_reg;
    if (op_valid) begin
      case (op_kind)
        alu_flags_pkg::OP_ADD,
        alu_flags_pkg::OP_ADC,
        alu_flags_pkg::OP_SUB,
        alu_flags_pkg::OP_SBC: begin
          op_flags[alu_flags_pkg::FLAG_CARRY]  = calc_bus.carry;        // RULE_01
          op_flags[alu_flags_pkg::FLAG_NIBBLE] = calc_bus.nibble_carry; // RULE_03
          op_flags[alu_flags_pkg::FLAG_ZERO]   = calc_bus.zero;         // RULE_04
          op_flags[alu_flags_pkg::FLAG_WRAP]   = calc_bus.wrap;         // RULE_05
          op_flags[alu_flags_pkg::FLAG_SIGN]   = calc_bus.wrap ^ calc_bus.result[7]; // RULE_06
          if (op_kind == alu_flags_pkg::OP_SUB) begin
            op_flags[alu_flags_pkg::FLAG_CHAIN] = calc_bus.zero; // RULE_07
          end else if (op_kind == alu_flags_pkg::OP_SBC) begin
            op_flags[alu_flags_pkg::FLAG_CHAIN] =
              arith_flag_reg[alu_flags_pkg::FLAG_CHAIN] & calc_bus.zero; // RULE_08
          end
        end
        alu_flags_pkg::OP_LOGIC: begin
          op_flags[alu_flags_pkg::FLAG_ZERO] = calc_bus.zero; // RULE_04
        end
        alu_flags_pkg::OP_RLC,
        alu_flags_pkg::OP_RRC: begin
          op_flags[alu_flags_pkg::FLAG_CARRY] = calc_bus.carry; // RULE_02
        end
        default: begin
          op_flags = arith_flag_reg; // RULE_09
        end
      endcase
    end
  end

  always_comb begin
    next_arith_flag_reg = op_flags;
    // Explicit write wins over the same cycle's ALU update; APB last
    if (instr_flag_write) begin
      next_arith_flag_reg = (op_flags & ~alu_flags_pkg::FLAG_WRITE_MASK)
                          | (instr_flag_data & alu_flags_pkg::FLAG_WRITE_MASK); // RULE_15 RULE_10
    end
    if (sw_flag_write) begin
      next_arith_flag_reg = (op_flags & ~alu_flags_pkg::FLAG_WRITE_MASK)
                          | (pwdata[7:0] & alu_flags_pkg::FLAG_WRITE_MASK); // RULE_15 RULE_13
    end
    // Timeout set beats a same-cycle clear so the event is not lost
    if (watchdog_clear_instr || halt_instr) begin
      next_arith_flag_reg[alu_flags_pkg::FLAG_DOG] = 1'b0; // RULE_11
    end
    if (watchdog_timeout) begin
      next_arith_flag_reg[alu_flags_pkg::FLAG_DOG] = 1'b1; // RULE_11
    end
    if (watchdog_clear_instr) begin
      next_arith_flag_reg[alu_flags_pkg::FLAG_SLEEP] = 1'b0; // RULE_12
    end
    if (halt_instr) begin
      next_arith_flag_reg[alu_flags_pkg::FLAG_SLEEP] = 1'b1; // RULE_12
    end
  end

  // Result kept for software; flags are never stacked by this block
  always_comb begin
    next_result_reg = result_reg;
    if (op_valid && (op_kind != alu_flags_pkg::OP_NONE)) begin
      next_result_reg = calc_bus.result; // RULE_14
    end
  end

  // Interrupt status: hardware set wins over software clear
  always_comb begin
    events = 3'h0;
    events[alu_flags_pkg::EVT_DOG]   = watchdog_timeout;
    events[alu_flags_pkg::EVT_SLEEP] = halt_instr;
    events[alu_flags_pkg::EVT_WRAP]  = next_arith_flag_reg[alu_flags_pkg::FLAG_WRAP]
                                     & ~arith_flag_reg[alu_flags_pkg::FLAG_WRAP];
    next_irq_status = irq_status;
    if (sw_irq_clear) begin
      next_irq_status = irq_status & ~pwdata[2:0];
    end
    next_irq_status = next_irq_status | events;
    next_irq_enable = irq_enable;
    if (sw_irq_enable) begin
      next_irq_enable = pwdata[2:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      arith_flag_reg <= alu_flags_pkg::FLAG_RESET; // RULE_13 RULE_11 RULE_12
      result_reg     <= 8'h00;
      irq_status     <= alu_flags_pkg::IRQ_RESET;
      irq_enable     <= alu_flags_pkg::IRQ_RESET;
      read_data      <= 32'h0000_0000;
      addr_bad       <= 1'b0;
    end else begin
      arith_flag_reg <= next_arith_flag_reg;
      result_reg     <= next_result_reg;
      irq_status     <= next_irq_status;
      irq_enable     <= next_irq_enable;
      read_data      <= next_read_data;
      addr_bad       <= next_addr_bad;
    end
  end

  assign prdata     = read_data;
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && addr_bad;
  assign flags      = arith_flag_reg;
  assign alu_result = result_reg;
  assign irq        = |(irq_status & irq_enable);

endmodule

// file: pkg/alu_flags_pkg.sv
// Purpose: Shared constants and types for the flag register block
// Assumes: 32-bit APB data, byte addresses, one word per register
// Notes:   Flag bit positions match the 8-bit flag register layout
package alu_flags_pkg;

  // Flag bit positions
  localparam int unsigned FLAG_CARRY      = 0;
  localparam int unsigned FLAG_NIBBLE     = 1;
  localparam int unsigned FLAG_ZERO       = 2;
  localparam int unsigned FLAG_WRAP       = 3;
  localparam int unsigned FLAG_SLEEP      = 4;
  localparam int unsigned FLAG_DOG        = 5;
  localparam int unsigned FLAG_CHAIN      = 6;
  localparam int unsigned FLAG_SIGN       = 7;

  // Bits that instructions and software may write
  localparam logic [7:0]  FLAG_WRITE_MASK = 8'hcf;
  localparam logic [7:0]  FLAG_RESET      = 8'h00;

  // Register byte offsets
  localparam int unsigned ADDR_W          = 12;
  localparam logic [11:0] ADDR_FLAGS      = 12'h000;
  localparam logic [11:0] ADDR_RESULT     = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h008;
  localparam logic [11:0] ADDR_IRQ_CLEAR  = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h010;

  // Interrupt event bits
  localparam int unsigned EVENT_W         = 3;
  localparam int unsigned EVT_DOG         = 0;
  localparam int unsigned EVT_SLEEP       = 1;
  localparam int unsigned EVT_WRAP        = 2;
  localparam logic [2:0]  IRQ_RESET       = 3'h0;

  // ALU operation classes
  typedef enum logic [2:0] {
    OP_ADD   = 3'b000,
    OP_ADC   = 3'b001,
    OP_SUB   = 3'b010,
    OP_SBC   = 3'b011,
    OP_LOGIC = 3'b100,
    OP_RLC   = 3'b101,
    OP_RRC   = 3'b110,
    OP_NONE  = 3'b111
  } alu_op_t;

endpackage

// file: pkg/flag_calc_if.sv
// Purpose: Carries one ALU operation and its raw flag results
// Assumes: Purely combinational path between the two modules
// Notes:   None
`timescale 1ns/1ps
interface flag_calc_if;
  alu_flags_pkg::alu_op_t op;
  logic [7:0]             op_a;
  logic [7:0]             op_b;
  logic                   carry_in;
  logic [7:0]             result;
  logic                   carry;
  logic                   nibble_carry;
  logic                   zero;
  logic                   wrap;

  modport calc (input op, op_a, op_b, carry_in,
                output result, carry, nibble_carry, zero, wrap);
  modport user (output op, op_a, op_b, carry_in,
                input result, carry, nibble_carry, zero, wrap);
endinterface

// file: hw/alu_flag_calc.sv
// Purpose: Computes an 8-bit ALU result and its raw flags
// Assumes: Subtraction is a plus inverted b plus carry
// Notes:   Carry out of a subtraction means no borrow
`timescale 1ns/1ps
module alu_flag_calc (
  flag_calc_if.calc calc
);

  logic [4:0] low_sum;
  logic [3:0] high7_sum;
  logic [8:0] full_sum;
  logic [7:0] b_eff;
  logic       cin_eff;

  always_comb begin
    b_eff   = calc.op_b;
    cin_eff = 1'b0;
    case (calc.op)
      alu_flags_pkg::OP_ADC: begin
        cin_eff = calc.carry_in;
      end
      alu_flags_pkg::OP_SUB: begin
        b_eff   = ~calc.op_b;
        cin_eff = 1'b1;
      end
      alu_flags_pkg::OP_SBC: begin
        b_eff   = ~calc.op_b;
        cin_eff = calc.carry_in;
      end
      default: begin
        b_eff   = calc.op_b;
        cin_eff = 1'b0;
      end
    endcase
  end

  always_comb begin
    low_sum   = {1'b0, calc.op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_eff};
    high7_sum = {1'b0, calc.op_a[6:4]} + {1'b0, b_eff[6:4]} + {3'h0, low_sum[4]};
    full_sum  = {1'b0, calc.op_a} + {1'b0, b_eff} + {8'h00, cin_eff};
  end

  always_comb begin
    calc.result       = full_sum[7:0];
    calc.carry        = full_sum[8];
    calc.nibble_carry = low_sum[4];
    calc.wrap         = high7_sum[3] ^ full_sum[8];
    case (calc.op)
      alu_flags_pkg::OP_LOGIC: begin
        calc.result = calc.op_a;
        calc.carry  = 1'b0;
        calc.wrap   = 1'b0;
      end
      alu_flags_pkg::OP_RLC: begin
        calc.result = {calc.op_a[6:0], calc.carry_in};
        calc.carry  = calc.op_a[7];
        calc.wrap   = 1'b0;
      end
      alu_flags_pkg::OP_RRC: begin
        calc.result = {calc.carry_in, calc.op_a[7:1]};
        calc.carry  = calc.op_a[0];
        calc.wrap   = 1'b0;
      end
      default: begin
        calc.result = full_sum[7:0];
      end
    endcase
    calc.zero = (calc.result == 8'h00);
  end

endmodule

// file: verification/alu_status_flags_asserts.sv
// Purpose: Concurrent checks on the flag register outputs
// Assumes: Ports of alu_status_flags only, one clock domain
// Notes:   Same-cycle flag writes mask the ALU update checks
`timescale 1ns/1ps
module alu_status_flags_asserts (
  // Clock and reset
  input wire logic                   clock,
  input wire logic                   reset,
  // APB
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [11:0]            paddr,
  input wire logic [3:0]             pstrb,
  // ALU
  input wire logic                   op_valid,
  input wire alu_flags_pkg::alu_op_t op_kind,
  input wire logic [7:0]             op_a,
  input wire logic [7:0]             op_b,
  input wire logic [7:0]             alu_result,
  // Instruction write and events
  input wire logic                   instr_flag_write,
  input wire logic [7:0]             instr_flag_data,
  input wire logic                   watchdog_clear_instr,
  input wire logic                   halt_instr,
  input wire logic                   watchdog_timeout,
  // Flags
  input wire logic [7:0]             flags
);
  wire logic       apbw   = psel & penable & pwrite & pstrb[0] & (paddr == alu_flags_pkg::ADDR_FLAGS);
  wire logic       upd    = op_valid & ~apbw & ~instr_flag_write;
  wire logic       arith  = upd & ~op_kind[2];
  wire logic       add_op = arith & (op_kind == alu_flags_pkg::OP_ADD);
  wire logic       sub_op = arith & (op_kind == alu_flags_pkg::OP_SUB);
  wire logic       sbc_op = arith & (op_kind == alu_flags_pkg::OP_SBC);
  wire logic [8:0] sum9   = {1'b0, op_a} + {1'b0, op_b};
  // Signed wrap of an add: equal signs in, other sign out
  wire logic       ovf    = (op_a[7] == op_b[7]) && (sum9[7] != op_a[7]);
  wire logic [7:0] imask  = instr_flag_data & alu_flags_pkg::FLAG_WRITE_MASK;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  add_carry_a: assert property (add_op |=> flags[0] == $past(sum9[8]))
    else $error("add carry wrong");
  zero_res_a: assert property (arith |=> flags[2] == (alu_result == 8'h00))
    else $error("zero flag mismatch");
  wrap_add_a: assert property (add_op |=> flags[3] == $past(ovf))
    else $error("add wrap wrong");
  sign_xor_a: assert property (arith |=> flags[7] == (flags[3] ^ alu_result[7]))
    else $error("sign flag wrong");
  chain_sub_a: assert property (sub_op |=> flags[6] == flags[2])
    else $error("chained zero wrong after sub");
  chain_sbc_a: assert property (sbc_op |=> flags[6] == ($past(flags[6]) & flags[2]))
    else $error("chained zero wrong after sbc");
  chain_keep_a: assert property (!sub_op && !sbc_op && !apbw && !instr_flag_write |=> $stable(flags[6]))
    else $error("chained zero changed");
  sys_keep_a: assert property ((apbw || instr_flag_write) && !watchdog_timeout && !halt_instr
    && !watchdog_clear_instr |=> $stable(flags[5:4])) else $error("system flags written");
  dog_set_a: assert property (watchdog_timeout |=> flags[5])
    else $error("timeout flag not set");
  halt_flags_a: assert property (halt_instr && !watchdog_timeout |=> flags[5:4] == 2'b01)
    else $error("halt flags wrong");
  instr_wins_a: assert property (instr_flag_write && !apbw |=>
    (flags & alu_flags_pkg::FLAG_WRITE_MASK) == $past(imask)) else $error("flag write lost");

  sbc_chain_c: cover property (sbc_op ##1 flags[6]);
  override_c: cover property (instr_flag_write && op_valid);
  halt_c: cover property (halt_instr ##1 flags[4]);
endmodule

// file: verification/tb_alu_status_flags.sv
// Purpose: Self-checking bench for the flag register block
// Assumes: Zero-wait APB slave, event inputs pulse one cycle
// Notes:   Expected flags come from a local reference model in t_ops, fixed values in the other tests
`timescale 1ns/1ps
bind alu_status_flags alu_status_flags_asserts u_chk (.clock(clock), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb), .op_valid(op_valid), .op_kind(op_kind),
  .op_a(op_a), .op_b(op_b), .alu_result(alu_result), .instr_flag_write(instr_flag_write),
  .instr_flag_data(instr_flag_data), .watchdog_clear_instr(watchdog_clear_instr), .halt_instr(halt_instr),
  .watchdog_timeout(watchdog_timeout), .flags(flags));
module tb_alu_status_flags;
  logic                   clock, reset, psel, penable, pwrite, op_valid, instr_flag_write, re;
  logic                   watchdog_clear_instr, halt_instr, watchdog_timeout, pready, pslverr, irq;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, rq;
  logic [3:0]             pstrb;
  alu_flags_pkg::alu_op_t op_kind;
  logic [7:0]             op_a, op_b, alu_result, instr_flag_data, flags, exp_f, exp_r;
  int                     checks, miscompares, cycles;

  alu_status_flags u_dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_valid(op_valid), .op_kind(op_kind), .op_a(op_a), .op_b(op_b), .alu_result(alu_result),
    .instr_flag_write(instr_flag_write), .instr_flag_data(instr_flag_data),
    .watchdog_clear_instr(watchdog_clear_instr), .halt_instr(halt_instr),
    .watchdog_timeout(watchdog_timeout), .flags(flags), .irq(irq));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Whole run is about 140 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic ev(input logic [2:0] v);
    @(posedge clock);
    {watchdog_timeout, halt_instr, watchdog_clear_instr} <= v;
    @(posedge clock);
    {watchdog_timeout, halt_instr, watchdog_clear_instr} <= 3'h0;
    #1;
  endtask

  function automatic logic [15:0] model(input logic [2:0] k, input logic [7:0] a, b, f, r0);
    logic [7:0] bb, r, nf;
    logic [8:0] s;
    bb = k[1] ? ~b : b;
    s  = {1'b0, a} + {1'b0, bb} + 9'(k[0] ? f[0] : k[1]);
    r  = a;
    nf = f;
    case (k)
      3'h0, 3'h1, 3'h2, 3'h3: begin
        r = s[7:0];
        nf[0] = s[8];
        nf[1] = s[4] ^ a[4] ^ bb[4];
        nf[2] = r == 8'h00;
        nf[3] = s[7] ^ a[7] ^ bb[7] ^ s[8];
        nf[7] = nf[3] ^ r[7];
        if (k == 3'h2) nf[6] = nf[2];
        if (k == 3'h3) nf[6] = f[6] & nf[2];
      end
      3'h4: nf[2] = a == 8'h00;
      3'h5: {nf[0], r} = {a, f[0]};
      3'h6: {r, nf[0]} = {f[0], a};
      default: r = r0;
    endcase
    return {r, nf};
  endfunction

  task automatic op(input logic [2:0] k, input logic [7:0] a, input logic [7:0] b);
    {exp_r, exp_f} = model(k, a, b, exp_f, exp_r);
    @(posedge clock);
    op_valid <= 1'b1;
    op_kind <= alu_flags_pkg::alu_op_t'(k);
    op_a <= a;
    op_b <= b;
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
  endtask

  task automatic t_ops;
    logic [7:0] pa [5] = '{8'h7f, 8'hff, 8'h80, 8'h10, 8'h0f};
    logic [7:0] pb [5] = '{8'h01, 8'h01, 8'h80, 8'h10, 8'hf1};
    check(32'(flags), 32'h0);
    for (int i = 0; i < 5; i++) begin
      for (int k = 0; k < 8; k++) begin
        op(3'(k), pa[i], pb[i]);
        check(32'(flags), 32'(exp_f));
        check(32'(alu_result), 32'(exp_r));
      end
    end
    $display("done t_ops");
  endtask

  task automatic t_override;
    @(posedge clock);
    op_valid <= 1'b1;
    op_kind <= alu_flags_pkg::OP_ADD;
    instr_flag_write <= 1'b1;
    instr_flag_data <= 8'hff;
    @(posedge clock);
    op_valid <= 1'b0;
    instr_flag_write <= 1'b0;
    #1 check(32'(flags), 32'hcf);
    check(32'(alu_result), 32'h00);
    $display("done t_override");
  endtask

  task automatic t_sys;
    ev(3'h4);
    check(32'(flags), 32'hef);
    apb(1'b1, alu_flags_pkg::ADDR_FLAGS, 32'h0);
    check(32'(flags), 32'h20);
    ev(3'h2);
    check(32'(flags), 32'h10);
    apb(1'b1, alu_flags_pkg::ADDR_FLAGS, 32'hff);
    apb(1'b0, alu_flags_pkg::ADDR_FLAGS, 32'h0);
    check(rq, 32'hdf);
    ev(3'h1);
    check(32'(flags), 32'hcf);
    pstrb <= 4'h0;
    apb(1'b1, alu_flags_pkg::ADDR_FLAGS, 32'h0);
    pstrb <= 4'hf;
    check(32'(flags), 32'hcf);
    $display("done t_sys");
  endtask

  task automatic t_irq;
    apb(1'b1, alu_flags_pkg::ADDR_IRQ_CLEAR, 32'h7);
    apb(1'b1, alu_flags_pkg::ADDR_IRQ_ENABLE, 32'h7);
    check(32'(irq), 32'h0);
    ev(3'h4);
    check(32'(irq), 32'h1);
    check(32'(flags), 32'hef);
    apb(1'b0, alu_flags_pkg::ADDR_IRQ_STATUS, 32'h0);
    check(rq, 32'h1);
    apb(1'b1, alu_flags_pkg::ADDR_IRQ_CLEAR, 32'h1);
    check(32'(irq), 32'h0);
    apb(1'b1, alu_flags_pkg::ADDR_IRQ_ENABLE, 32'h0);
    ev(3'h2);
    check(32'(irq), 32'h0);
    apb(1'b0, alu_flags_pkg::ADDR_IRQ_STATUS, 32'h0);
    check(rq, 32'h2);
    apb(1'b1, alu_flags_pkg::ADDR_RESULT, 32'h5a);
    apb(1'b0, alu_flags_pkg::ADDR_RESULT, 32'h0);
    check(rq, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    check({rq[30:0], re}, 32'h1);
    $display("done t_irq");
  endtask

  task automatic report_and_stop;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    {reset, psel, penable, pwrite, op_valid, instr_flag_write} = 6'h20;
    {watchdog_clear_instr, halt_instr, watchdog_timeout} = 3'h0;
    {paddr, pwdata, pstrb, op_a, op_b, instr_flag_data} = '0;
    pstrb = 4'hf;
    op_kind = alu_flags_pkg::OP_NONE;
    {exp_f, exp_r} = 16'h0;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    #1;
    t_ops();
    t_override();
    t_sys();
    t_irq();
    report_and_stop();
  end
endmodule
